// ===== hw/icm_pkg.sv
// package of the input capture block: register map, field layout, modes and states
// assumes a 32-bit avalon-mm slave port with byte addresses, aligned words only
package icm_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ICM_ADDR_W = 4;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFF_CONTROL = 4'h0;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFF_STATUS = 4'h4;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFF_BUFFER = 4'h8;
  localparam logic [ICM_ADDR_W-1:0] ICM_OFF_TIMEBASE = 4'hC;

  // ****************************************
  // input_capture_control fields
  // ****************************************
  localparam int ICM_CTL_ENABLE = 15;
  localparam int ICM_CTL_FIRST_RISING = 6;
  localparam int ICM_CTL_MODE_LSB = 0;
  localparam int ICM_MODE_W = 3;
  localparam logic [31:0] ICM_CTL_WRITE_MASK = 32'h0000_8047;
  localparam logic [31:0] ICM_CTL_RESET = 32'h0000_0000;

  // ****************************************
  // status fields
  // ****************************************
  localparam int ICM_ST_EVENT = 0;
  localparam int ICM_ST_NOT_EMPTY = 1;
  localparam int ICM_ST_FULL = 2;
  localparam int ICM_ST_OVERFLOW = 3;
  localparam int ICM_ST_LEVEL = 4;

  // ****************************************
  // capture_mode_select codes
  // ****************************************
  typedef enum logic [2:0] {
    ICM_MODE_OFF = 3'h0,
    ICM_MODE_EDGE_DETECT = 3'h1,
    ICM_MODE_FALLING = 3'h2,
    ICM_MODE_RISING = 3'h3,
    ICM_MODE_DIV4 = 3'h4,
    ICM_MODE_DIV16 = 3'h5,
    ICM_MODE_FIRST_THEN_ALL = 3'h6,
    ICM_MODE_IRQ_ONLY = 3'h7
  } icm_mode_t;

  localparam logic [3:0] ICM_PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] ICM_PRESCALE_16_LAST = 4'hF;

  // ****************************************
  // sequencer states, one-hot
  // ****************************************
  typedef enum logic [2:0] {
    ICM_ST_IDLE = 3'b001,
    ICM_ST_WAIT_FIRST = 3'b010,
    ICM_ST_RUN = 3'b100
  } icm_state_t;

endpackage

// ===== hw/icm_capture_mem.sv
// small capture memory: one write port, one read port with registered read data
// assumes the caller keeps pointers in range and presents the read pointer it will hold next
`timescale 1ns/1ps
module icm_capture_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH_LOG = 2
) (
  input wire logic clock,
  input wire logic write_enable,
  input wire logic [DEPTH_LOG-1:0] write_address,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic [DEPTH_LOG-1:0] read_address,
  output logic [WIDTH-1:0] read_data
);

  logic [WIDTH-1:0] store [2**DEPTH_LOG];

  // no reset on the array: contents are only read after being written
  always_ff @(posedge clock)
  begin
    if (write_enable)
    begin
      store[write_address] <= write_data;
    end
    // a write into the slot being read passes straight through, so a fresh entry never reads stale
    if (write_enable && write_address == read_address)
    begin
      read_data <= write_data;
    end
    else
    begin
      read_data <= store[read_address];
    end
  end

endmodule // icm_capture_mem

// ===== hw/icm_input_capture.sv
// input capture unit: edge sampling, mode decode, prescaler, capture buffer and register slave
// assumes capture_input is asynchronous to clock and the bus master follows avalon-mm rules
`timescale 1ns/1ps

// Overview of operation
// - mode 000 disables unit, no events
// - mode 001 reacts to every edge
// - mode 010 captures falling edges only
// - mode 011 captures rising edges only
// - mode 100 captures every fourth rising edge
// - mode 101 captures every sixteenth rising edge
// - mode 110 chosen edge first, then every edge
// - mode 111 interrupt only, in low power
module icm_input_capture
  import icm_pkg::*;
#(
  parameter int TIMEBASE_W = 32,
  parameter int DEPTH_LOG = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic capture_input,
  input wire logic low_power_state,
  input wire logic [ICM_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic capture_event,
  output logic edge_interrupt
);

  // ****************************************
  // state
  // ****************************************
  logic [2:0] sync, next_sync;
  logic level, next_level;
  logic [31:0] control, next_control;
  logic event_flag, next_event_flag;
  logic overflow, next_overflow;
  logic [3:0] prescale, next_prescale;
  icm_state_t state, next_state;
  logic [TIMEBASE_W-1:0] timebase, next_timebase;
  logic [DEPTH_LOG:0] write_ptr, next_write_ptr;
  logic [DEPTH_LOG:0] read_ptr, next_read_ptr;
  logic bus_done, next_bus_done;
  logic [31:0] readdata_q, next_readdata;
  logic capture_event_q, next_capture_event;
  logic edge_interrupt_q, next_edge_interrupt;

  logic enabled, rise, fall, take;
  logic buf_empty, buf_full, bus_accept;
  icm_mode_t mode;
  logic [31:0] mem_read_data, status_word, write_bits;

  assign enabled = control[ICM_CTL_ENABLE];
  assign mode = icm_mode_t'(control[ICM_CTL_MODE_LSB +: ICM_MODE_W]);
  assign buf_empty = (write_ptr == read_ptr);
  assign buf_full = (write_ptr[DEPTH_LOG] != read_ptr[DEPTH_LOG])
    && (write_ptr[DEPTH_LOG-1:0] == read_ptr[DEPTH_LOG-1:0]);
  // a change counts once the second and third stages agree and differ from the held level
  assign rise = (sync[1] == sync[2]) && sync[2] && !level;
  assign fall = (sync[1] == sync[2]) && !sync[2] && level;
  assign bus_accept = (avs_read || avs_write) && bus_done;
  // one wait cycle on every access; the answer comes on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !bus_done;
  assign avs_readdata = readdata_q;
  assign capture_event = capture_event_q;
  assign edge_interrupt = edge_interrupt_q;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ICM_ST_EVENT] = event_flag;
    status_word[ICM_ST_NOT_EMPTY] = !buf_empty;
    status_word[ICM_ST_FULL] = buf_full;
    status_word[ICM_ST_OVERFLOW] = overflow;
    status_word[ICM_ST_LEVEL] = level;
  end

  // ****************************************
  // capture buffer
  // ****************************************
  icm_capture_mem #(
    .WIDTH(32),
    .DEPTH_LOG(DEPTH_LOG)
  ) u_mem (
    .clock(clock),
    .write_enable(take && !buf_full),
    .write_address(write_ptr[DEPTH_LOG-1:0]),
    .write_data(32'(timebase)),
    .read_address(next_read_ptr[DEPTH_LOG-1:0]),
    .read_data(mem_read_data)
  );

  // ****************************************
  // edge decode and sequencer
  // ****************************************
  always_comb
  begin
    next_sync = {sync[1:0], capture_input};
    next_level = (sync[1] == sync[2]) ? sync[2] : level;
    next_timebase = timebase + TIMEBASE_W'(1);
    next_prescale = prescale;
    next_state = state;
    take = 1'b0;
    next_edge_interrupt = 1'b0;
    case (state)
      ICM_ST_IDLE:
      begin
        next_prescale = 4'h0;
        if (enabled && mode != ICM_MODE_OFF)
        begin
          next_state = (mode == ICM_MODE_FIRST_THEN_ALL) ? ICM_ST_WAIT_FIRST : ICM_ST_RUN;
        end
      end
      ICM_ST_WAIT_FIRST:
      begin
        // the configured polarity opens the sequence and is itself captured
        if (control[ICM_CTL_FIRST_RISING] ? rise : fall)
        begin
          take = 1'b1;
          next_state = ICM_ST_RUN;
        end
      end
      ICM_ST_RUN:
      begin
        case (mode)
          ICM_MODE_EDGE_DETECT: take = rise || fall;
          ICM_MODE_FALLING: take = fall;
          ICM_MODE_RISING: take = rise;
          ICM_MODE_DIV4, ICM_MODE_DIV16:
          begin
            if (rise)
            begin
              if (prescale == ((mode == ICM_MODE_DIV4) ? ICM_PRESCALE_4_LAST : ICM_PRESCALE_16_LAST))
              begin
                take = 1'b1;
                next_prescale = 4'h0;
              end
              else
              begin
                next_prescale = prescale + 4'h1;
              end
            end
          end
          ICM_MODE_FIRST_THEN_ALL: take = rise || fall;
          // no value is stored; edges only raise the interrupt while low_power_state is high
          ICM_MODE_IRQ_ONLY: next_edge_interrupt = low_power_state && (rise || fall);
          default: take = 1'b0;
        endcase
      end
      default:
      begin
        next_state = ICM_ST_IDLE;
      end
    endcase
    // a disable or a switch to mode 000 restarts the sequence and prescaler
    if (!enabled || mode == ICM_MODE_OFF)
    begin
      next_state = ICM_ST_IDLE;
      take = 1'b0;
      next_edge_interrupt = 1'b0;
    end
    if (take)
    begin
      next_edge_interrupt = 1'b1;
    end
    next_capture_event = take;
  end

  // ****************************************
  // register slave, buffer pointers and flags
  // ****************************************
  always_comb
  begin
    next_control = control;
    next_event_flag = event_flag;
    next_overflow = overflow;
    next_write_ptr = write_ptr;
    next_read_ptr = read_ptr;
    next_bus_done = (avs_read || avs_write) && !bus_done;
    next_readdata = readdata_q;
    for (int b = 0; b < 4; b++)
    begin
      write_bits[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8] : 8'h00;
    end
    if (avs_read && !bus_done)
    begin
      case (avs_address)
        ICM_OFF_CONTROL: next_readdata = control;
        ICM_OFF_STATUS: next_readdata = status_word;
        ICM_OFF_BUFFER: next_readdata = buf_empty ? 32'h0000_0000 : mem_read_data;
        ICM_OFF_TIMEBASE: next_readdata = 32'(timebase);
        default: next_readdata = 32'h0000_0000;
      endcase
    end
    if (bus_accept && avs_write)
    begin
      case (avs_address)
        ICM_OFF_CONTROL:
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (avs_byteenable[b])
            begin
              next_control[8*b +: 8] = avs_writedata[8*b +: 8] & ICM_CTL_WRITE_MASK[8*b +: 8];
            end
          end
        end
        ICM_OFF_STATUS:
        begin
          if (write_bits[ICM_ST_EVENT])
          begin
            next_event_flag = 1'b0;
          end
          if (write_bits[ICM_ST_OVERFLOW])
          begin
            next_overflow = 1'b0;
          end
        end
        default:
        begin
          next_control = control;
        end
      endcase
    end
    if (bus_accept && avs_read && avs_address == ICM_OFF_BUFFER && !buf_empty)
    begin
      next_read_ptr = read_ptr + (DEPTH_LOG+1)'(1);
    end
    // a capture in the same cycle as a clear leaves the flag set
    if (take)
    begin
      next_event_flag = 1'b1;
      if (buf_full)
      begin
        next_overflow = 1'b1;
      end
      else
      begin
        next_write_ptr = write_ptr + (DEPTH_LOG+1)'(1);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sync <= 3'h0;
      level <= 1'b0;
      control <= ICM_CTL_RESET;
      event_flag <= 1'b0;
      overflow <= 1'b0;
      prescale <= 4'h0;
      state <= ICM_ST_IDLE;
      timebase <= '0;
      write_ptr <= '0;
      read_ptr <= '0;
      bus_done <= 1'b0;
      readdata_q <= 32'h0000_0000;
      capture_event_q <= 1'b0;
      edge_interrupt_q <= 1'b0;
    end
    else
    begin
      sync <= next_sync;
      level <= next_level;
      control <= next_control;
      event_flag <= next_event_flag;
      overflow <= next_overflow;
      prescale <= next_prescale;
      state <= next_state;
      timebase <= next_timebase;
      write_ptr <= next_write_ptr;
      read_ptr <= next_read_ptr;
      bus_done <= next_bus_done;
      readdata_q <= next_readdata;
      capture_event_q <= next_capture_event;
      edge_interrupt_q <= next_edge_interrupt;
    end
  end

endmodule // icm_input_capture

// ===== sim/icm_input_capture_properties.sv
// concurrent checks of the input capture unit, seen from its ports only
// assumes the bus master holds each request until waitrequest is low
`timescale 1ns/1ps
module icm_input_capture_properties
  import icm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic capture_input,
  input wire logic low_power_state,
  input wire logic [ICM_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic capture_event,
  input wire logic edge_interrupt
);
  // ****
  // shadow of control, age of config and of pin level
  // ****
  logic [31:0] ctl;
  logic [31:0] next_ctl;
  logic [3:0] age;
  logic [3:0] next_age;
  logic [3:0] pin_age;
  logic [3:0] next_pin_age;
  logic pin_q;
  logic settled;
  logic [2:0] md;
  always_comb
  begin
    next_ctl = ctl;
    next_age = (age == 4'hF) ? age : age + 4'h1;
    next_pin_age = (capture_input != pin_q) ? 4'h0 : ((pin_age == 4'hF) ? pin_age : pin_age + 4'h1);
    if (avs_write && !avs_waitrequest && avs_address == ICM_OFF_CONTROL)
    begin
      next_ctl = avs_writedata & ICM_CTL_WRITE_MASK;
      next_age = 4'h0;
    end
    if (reset)
    begin
      next_ctl = 32'h0;
      next_age = 4'hF;
      next_pin_age = 4'hF;
    end
  end
  always_ff @(posedge clock)
  begin
    ctl <= next_ctl;
    age <= next_age;
    pin_age <= next_pin_age;
    pin_q <= capture_input;
  end
  // pipeline of the synchroniser must drain before a new mode is judged
  assign settled = (age >= 4'hA);
  assign md = ctl[2:0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request not held off by a wait cycle");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_off_quiet: assert property (settled && (!ctl[ICM_CTL_ENABLE] || md == 3'h0) |-> !capture_event && !edge_interrupt)
    else $error("event while unit disabled");
  a_irq_pairs: assert property (settled && ctl[ICM_CTL_ENABLE] && md != 3'h7 |-> edge_interrupt == capture_event)
    else $error("interrupt and capture disagree");
  a_irq_only_nocap: assert property (settled && md == 3'h7 |-> !capture_event)
    else $error("capture in interrupt-only mode");
  a_irq_awake_quiet: assert property (settled && md == 3'h7 && !low_power_state && !$past(low_power_state) |-> !edge_interrupt)
    else $error("interrupt-only mode fired while awake");
  a_event_pulse: assert property (capture_event |=> !capture_event)
    else $error("capture pulse longer than one cycle");
  a_event_delay: assert property (capture_event |-> pin_age >= 4'h2 && pin_age <= 4'h8)
    else $error("capture not tied to a recent pin edge");
  a_rise_level: assert property (settled && md inside {3'h3, 3'h4, 3'h5} && capture_event |-> capture_input)
    else $error("capture on a falling edge in a rising mode");
  a_fall_level: assert property (settled && md == 3'h2 && capture_event |-> !capture_input)
    else $error("capture on a rising edge in falling mode");
endmodule // icm_input_capture_properties

bind icm_input_capture icm_input_capture_properties i_props (.clock(clock), .reset(reset),
  .capture_input(capture_input), .low_power_state(low_power_state), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_event(capture_event),
  .edge_interrupt(edge_interrupt));

// ===== sim/icm_pin_model.sv
// model of the external signal: a burst of alternating edges on request
// assumes an even edge count so the pin rests low between bursts
`timescale 1ns/1ps
module icm_pin_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] edges,
  input wire logic [3:0] gap,
  output logic pin,
  output logic busy
);
  logic [7:0] left;
  logic [4:0] hold;
  // each level lasts at least 9 cycles so the synchroniser always sees it
  always @(posedge clock)
  begin
    if (reset)
    begin
      pin <= 1'b0;
      busy <= 1'b0;
      left <= 8'h0;
      hold <= 5'h0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      left <= edges;
      hold <= 5'(gap) + 5'h8;
    end
    else if (busy && hold == 5'h0)
    begin
      pin <= ~pin;
      left <= left - 8'h1;
      hold <= 5'(gap) + 5'h8;
      busy <= (left != 8'h1);
    end
    else if (busy)
      hold <= hold - 5'h1;
  end
endmodule // icm_pin_model

// ===== sim/icm_input_capture_tb.sv
// self-checking bench of the input capture unit with a pin model
// assumes the checker is bound to the unit by its own file
`timescale 1ns/1ps
module icm_input_capture_tb;
  import icm_pkg::*;
  logic clock = 1'b0;
  logic reset, pin, low_power_state, avs_read, avs_write, avs_waitrequest, capture_event, edge_interrupt;
  logic start, busy, fr;
  logic [3:0] avs_address, gap;
  logic [7:0] edges;
  logic [31:0] avs_writedata, avs_readdata, rd, c, prev;
  int errors = 0;
  int checked = 0;
  int seed = 32'h2B81;
  integer ev_n = 0;
  integer irq_n = 0;
  int i, j, m, n, x, k, e0, q0;
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    // four-state counts, so an unknown pulse poisons the total instead of counting as zero
    if (!reset)
    begin
      ev_n <= ev_n + capture_event;
      irq_n <= irq_n + edge_interrupt;
    end
  end
  icm_input_capture i_icm_input_capture (.clock(clock), .reset(reset), .capture_input(pin),
    .low_power_state(low_power_state), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_event(capture_event), .edge_interrupt(edge_interrupt));
  icm_pin_model i_icm_pin_model (.clock(clock), .reset(reset), .start(start), .edges(edges), .gap(gap),
    .pin(pin), .busy(busy));
  // ****
  // tasks
  // ****
  task automatic end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // entered just after a rising edge; returns one edge after the release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (avs_waitrequest !== 1'b0 && t < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      errors++;
      end_sim;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  function automatic int exp_caps(input int md, input int ne, input logic first_rise);
    case (md)
      1: return ne;
      2, 3: return ne / 2;
      4: return ne / 8;
      5: return ne / 32;
      6: return first_rise ? ne : ne - 1;
      default: return 0;
    endcase
  endfunction
  // ****
  // main sequence: every mode once, interrupt-only also in low power
  // ****
  initial
  begin
    reset = 1'b1;
    low_power_state = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    start = 1'b0;
    edges = 8'h0;
    gap = 4'h0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    bus(1'b0, ICM_OFF_CONTROL, 32'h0, rd);
    chk("control after reset", ICM_CTL_RESET, rd);
    bus(1'b0, ICM_OFF_STATUS, 32'h0, rd);
    chk("status after reset", 32'h0, rd);
    // back-to-back timebase reads are three clocks apart with one wait cycle each
    bus(1'b0, ICM_OFF_TIMEBASE, 32'h0, prev);
    bus(1'b0, ICM_OFF_TIMEBASE, 32'h0, rd);
    chk("timebase step", 32'h3, rd - prev);
    for (i = 0; i < 9; i++)
    begin
      m = (i > 7) ? 7 : i;
      n = 32 + 2 * int'($unsigned($random(seed)) % 4);
      fr = 1'($random(seed));
      bus(1'b1, ICM_OFF_CONTROL, 32'h0, rd);
      @(posedge clock);
      low_power_state <= (i == 8);
      c = 32'h8000 | (32'(fr) << ICM_CTL_FIRST_RISING) | 32'(m);
      bus(1'b1, ICM_OFF_CONTROL, c, rd);
      bus(1'b0, ICM_OFF_CONTROL, 32'h0, rd);
      chk("control", c, rd);
      e0 = ev_n;
      q0 = irq_n;
      gap <= 4'($random(seed));
      edges <= 8'(n);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      @(posedge clock);
      k = 0;
      while (busy !== 1'b0 && k < 2000)
      begin
        @(posedge clock);
        k++;
      end
      if (k == 2000)
      begin
        errors++;
        end_sim;
      end
      repeat (12) @(posedge clock);
      x = exp_caps(m, n, fr);
      chk("capture count", 32'(x), 32'(ev_n - e0));
      chk("interrupt count", 32'((m == 7) ? ((i == 8) ? n : 0) : x), 32'(irq_n - q0));
      bus(1'b0, ICM_OFF_STATUS, 32'h0, rd);
      chk("status", 32'({1'b0, x > 4, x >= 4, x > 0}), 32'(rd[4:1]));
      chk("event flag", 32'(x > 0), 32'(rd[ICM_ST_EVENT]));
      prev = 32'h0;
      for (j = 0; j < 6; j++)
      begin
        bus(1'b0, ICM_OFF_BUFFER, 32'h0, rd);
        if (j < x && j < 4)
          chk("buffer order", 32'h1, 32'(rd > prev));
        else
          chk("buffer empty", 32'h0, rd);
        prev = rd;
      end
      bus(1'b1, ICM_OFF_STATUS, 32'hF, rd);
    end
    end_sim;
  end
endmodule // icm_input_capture_tb
